/* hw/rcs_pkg.sv */
// constants of the coexistence status and interrupt register bank
package rcs_pkg;

	// ==========================================================
	// register map
	localparam logic [31:0] RCS_BASE_OFF      = 32'h50002f00;
	localparam logic [31:0] RCS_CTRL_OFF      = 32'h50002f00;
	localparam logic [31:0] RCS_STAT_OFF      = 32'h50002f02;
	localparam logic [31:0] RCS_MASK_OFF      = 32'h50002f04;
	localparam logic [31:0] RCS_EVT_OFF       = 32'h50002f06;
	localparam logic [31:0] RCS_CLR_OFF       = 32'h50002f08;
	localparam int          RCS_ADR_W         = 8;
	localparam int          RCS_REG_W         = 16;

	// ==========================================================
	// control register fields
	localparam int          RCS_CTRL_PRG_BIT  = 0;
	localparam int          RCS_CTRL_EXTF_BIT = 1;
	localparam logic [15:0] RCS_CTRL_RST      = 16'h0000;
	localparam logic [15:0] RCS_CTRL_WMASK    = 16'h0003;

	// ==========================================================
	// arbiter status fields
	localparam int          RCS_ST_EXT0_BIT   = 10;
	localparam int          RCS_ST_PRI_BIT    = 9;
	localparam int          RCS_ST_ACT_BIT    = 8;
	localparam int          RCS_ST_CLOS_BIT   = 7;
	localparam int          RCS_ST_CHO_LSB    = 5;
	localparam int          RCS_ST_IDX_LSB    = 0;

	// ==========================================================
	// choice codes and entry indices
	localparam logic [1:0]  RCS_CHO_NONE      = 2'h0;
	localparam logic [1:0]  RCS_CHO_ONCHIP    = 2'h1;
	localparam logic [1:0]  RCS_CHO_EXT       = 2'h3;
	localparam logic [4:0]  RCS_IDX_NULL      = 5'h00;
	localparam logic [4:0]  RCS_IDX_ONCHIP    = 5'h01;
	localparam logic [4:0]  RCS_IDX_EXT       = 5'h02;

	// ==========================================================
	// event positions, mask layout
	localparam int          RCS_EV_SWITCH     = 15;
	localparam int          RCS_EV_STARTMID   = 14;
	localparam int          RCS_EV_CLOSEBRK   = 13;
	localparam int          RCS_EV_BUSY_F     = 12;
	localparam int          RCS_EV_BUSY_R     = 11;
	localparam int          RCS_EV_ONACT_F    = 10;
	localparam int          RCS_EV_ONACT_R    = 9;
	localparam int          RCS_EV_EXT_F      = 6;
	localparam int          RCS_EV_EXT_R      = 5;
	localparam int          RCS_EV_PRI_F      = 4;
	localparam int          RCS_EV_PRI_R      = 3;
	localparam int          RCS_EV_ACT_F      = 2;
	localparam int          RCS_EV_ACT_R      = 1;
	localparam int          RCS_MASK_CPU_BIT  = 0;
	localparam logic [15:0] RCS_EV_USED       = 16'hfe7e;
	localparam logic [15:0] RCS_MASK_RST      = 16'h0000;

	// ==========================================================
	// timing
	localparam int          RCS_CLK_MHZ       = 25;
	localparam int          RCS_CLOSE_NS      = 80;
	localparam int          RCS_CLOSE_CYC     = (RCS_CLOSE_NS * RCS_CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		RCS_S_NONE,
		RCS_S_ONCHIP,
		RCS_S_EXT,
		RCS_S_CLOSING
	} rcs_state_e;

	// byte address of a register from its printed offset
	function automatic logic [RCS_ADR_W-1:0] rcs_byte_adr(input logic [31:0] off);
		logic [31:0] idx;
		idx = off - RCS_BASE_OFF;
		return {idx[RCS_ADR_W-3:0], 2'h0};
	endfunction : rcs_byte_adr

endpackage : rcs_pkg

/* hw/rcs_top.sv */
// coexistence arbiter with status, event and interrupt registers on classic wishbone
// ==========================================================
// Summary of operation
// - status bits 10,9,8 show live pin levels
// - status bit 7 shows closing sub-state
// - choice field codes none 0, onchip 1, external 3
// - no owner means priority output low
// - stay no owner while nobody active
// - programming and transaction done gives no owner
// - programming blocks all new arbitration decisions
// - bits 4:0 hold last winning entry, zero only after reset or while programming with no owner
// - masked event flags set aggregate interrupt flag
// - mask bit 0 gates aggregate flag to cpu
// - flag owner switch, ignoring passes through none
// - flag closing entered during owner tx/rx
// - edge events on activity signals, clear on read
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps

module rcs_top
	import rcs_pkg::*;
#(
	parameter int CLOSE_CYCLES = RCS_CLOSE_CYC
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [RCS_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic                 external_activity_in0_i,
	input  wire logic                 onchip_request_i,
	input  wire logic                 onchip_txrx_en_i,
	input  wire logic                 ext_txrx_en_i,
	input  wire logic                 radio_busy_i,
	output logic                      onchip_priority_out_o,
	output logic                      onchip_activity_out_o,
	output logic                      onchip_grant_o,
	output logic                      ext_grant_o,
	output logic                      irq_o
);

	// ==========================================================
	// elaboration check of the closing length
	if (CLOSE_CYCLES < 1 || CLOSE_CYCLES > 255) begin : g_close_range
		$error("CLOSE_CYCLES out of range");
	end

	localparam logic [RCS_ADR_W-1:0] A_CTRL = rcs_byte_adr(RCS_CTRL_OFF);
	localparam logic [RCS_ADR_W-1:0] A_STAT = rcs_byte_adr(RCS_STAT_OFF);
	localparam logic [RCS_ADR_W-1:0] A_MASK = rcs_byte_adr(RCS_MASK_OFF);
	localparam logic [RCS_ADR_W-1:0] A_EVT  = rcs_byte_adr(RCS_EVT_OFF);
	localparam logic [RCS_ADR_W-1:0] A_CLR  = rcs_byte_adr(RCS_CLR_OFF);
	localparam logic [7:0]           CLOSE_LAST = 8'(CLOSE_CYCLES - 1);

	// ==========================================================
	// declarations
	rcs_state_e  state_ff;
	logic [1:0]  choice_ff;
	logic        closing_ff;
	logic [4:0]  win_idx_ff;
	logic [7:0]  close_cnt_ff;
	logic [1:0]  owner_ff;
	logic [1:0]  last_mac_ff;
	logic [15:0] ctrl_ff;
	logic [15:0] mask_ff;
	logic [15:0] evt_ff;
	logic [15:0] nxt_evt;
	logic [15:0] ev_set;
	logic [15:0] ev_clr;
	logic        busy_prev_ff;
	logic        onact_prev_ff;
	logic        ext_prev_ff;
	logic        pri_prev_ff;
	logic        act_prev_ff;
	logic        nxt_pri;
	logic        nxt_act;
	logic        req;
	logic        wr;
	logic        rd;
	logic [15:0] wmask;
	logic [15:0] stat_word;
	logic [15:0] rd_word;
	logic        prg;
	logic        onchip_active;
	logic        ext_active;
	logic        owner_active;
	logic        owner_txrx;
	logic        agg_flag;
	logic        enter_closing;
	logic        new_mac;
	logic [1:0]  new_choice;

	// ==========================================================
	// bus decode
	assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr    = req & wb_we_i;
	assign rd    = req & ~wb_we_i;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= RCS_CTRL_RST;
		end else if (wr && wb_adr_i == A_CTRL) begin
			ctrl_ff <= (ctrl_ff & ~(wmask & RCS_CTRL_WMASK)) | (wb_dat_i[15:0] & wmask & RCS_CTRL_WMASK);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_ff <= RCS_MASK_RST;
		end else if (wr && wb_adr_i == A_MASK) begin
			mask_ff <= (mask_ff & ~(wmask & (RCS_EV_USED | 16'h0001)))
				| (wb_dat_i[15:0] & wmask & (RCS_EV_USED | 16'h0001));
		end
	end

	// ==========================================================
	// read mux
	always_comb begin
		stat_word                                = 16'h0000;
		stat_word[RCS_ST_EXT0_BIT]               = external_activity_in0_i;
		stat_word[RCS_ST_PRI_BIT]                = onchip_priority_out_o;
		stat_word[RCS_ST_ACT_BIT]                = onchip_activity_out_o;
		stat_word[RCS_ST_CLOS_BIT]               = closing_ff;
		stat_word[RCS_ST_CHO_LSB+1:RCS_ST_CHO_LSB] = choice_ff;
		stat_word[RCS_ST_IDX_LSB+4:RCS_ST_IDX_LSB] = win_idx_ff;
	end

	always_comb begin
		case (wb_adr_i)
			A_CTRL: rd_word = ctrl_ff;
			A_STAT: rd_word = stat_word;
			A_MASK: rd_word = mask_ff;
			A_EVT:  rd_word = evt_ff;
			default: rd_word = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (rd) begin
			wb_dat_o <= {16'h0000, rd_word};
		end
	end

	// ==========================================================
	// arbiter
	assign prg           = ctrl_ff[RCS_CTRL_PRG_BIT];
	assign onchip_active = onchip_request_i;
	assign ext_active    = external_activity_in0_i;
	assign owner_active  = (state_ff == RCS_S_ONCHIP) ? onchip_active : ext_active;
	assign owner_txrx    = (owner_ff == RCS_CHO_ONCHIP) ? onchip_txrx_en_i : ext_txrx_en_i;
	assign enter_closing = (state_ff == RCS_S_ONCHIP || state_ff == RCS_S_EXT) && !owner_active;

	always_comb begin
		new_choice = RCS_CHO_NONE;
		if (state_ff == RCS_S_NONE && !prg) begin
			if (onchip_active && !(ext_active && ctrl_ff[RCS_CTRL_EXTF_BIT])) begin
				new_choice = RCS_CHO_ONCHIP;
			end else if (ext_active) begin
				new_choice = RCS_CHO_EXT;
			end
		end
	end
	assign new_mac = new_choice != RCS_CHO_NONE;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff     <= RCS_S_NONE;
			choice_ff    <= RCS_CHO_NONE;
			closing_ff   <= 1'b0;
			close_cnt_ff <= 8'h00;
			owner_ff     <= RCS_CHO_NONE;
		end else begin
			case (state_ff)
				RCS_S_NONE: begin
					choice_ff <= new_choice;
					owner_ff  <= new_choice;
					if (new_choice == RCS_CHO_ONCHIP) begin
						state_ff <= RCS_S_ONCHIP;
					end else if (new_choice == RCS_CHO_EXT) begin
						state_ff <= RCS_S_EXT;
					end
				end
				RCS_S_ONCHIP, RCS_S_EXT: begin
					if (enter_closing) begin
						state_ff     <= RCS_S_CLOSING;
						closing_ff   <= 1'b1;
						close_cnt_ff <= CLOSE_LAST;
					end
				end
				RCS_S_CLOSING: begin
					if (close_cnt_ff == 8'h00) begin
						state_ff   <= RCS_S_NONE;
						closing_ff <= 1'b0;
						choice_ff  <= RCS_CHO_NONE;
						owner_ff   <= RCS_CHO_NONE;
					end else begin
						close_cnt_ff <= close_cnt_ff - 8'h01;
					end
				end
				default: begin
					state_ff   <= RCS_S_NONE;
					choice_ff  <= RCS_CHO_NONE;
					closing_ff <= 1'b0;
					owner_ff   <= RCS_CHO_NONE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win_idx_ff <= RCS_IDX_NULL;
		end else if (state_ff == RCS_S_NONE && prg) begin
			win_idx_ff <= RCS_IDX_NULL;
		end else if (new_choice == RCS_CHO_ONCHIP) begin
			win_idx_ff <= RCS_IDX_ONCHIP;
		end else if (new_choice == RCS_CHO_EXT) begin
			win_idx_ff <= RCS_IDX_EXT;
		end
	end

	// ==========================================================
	// pins and grants
	assign nxt_pri = (state_ff == RCS_S_ONCHIP) && onchip_active;
	assign nxt_act = onchip_active;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			onchip_priority_out_o <= 1'b0;
			onchip_activity_out_o <= 1'b0;
			onchip_grant_o        <= 1'b0;
			ext_grant_o           <= 1'b0;
		end else begin
			onchip_priority_out_o <= nxt_pri;
			onchip_activity_out_o <= nxt_act;
			onchip_grant_o        <= state_ff == RCS_S_ONCHIP || (state_ff == RCS_S_CLOSING && owner_ff == RCS_CHO_ONCHIP);
			ext_grant_o           <= state_ff == RCS_S_EXT || (state_ff == RCS_S_CLOSING && owner_ff == RCS_CHO_EXT);
		end
	end

	// ==========================================================
	// edge history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_prev_ff  <= 1'b0;
			onact_prev_ff <= 1'b0;
			ext_prev_ff   <= 1'b0;
			pri_prev_ff   <= 1'b0;
			act_prev_ff   <= 1'b0;
		end else begin
			busy_prev_ff  <= radio_busy_i;
			onact_prev_ff <= onchip_active;
			ext_prev_ff   <= ext_active;
			pri_prev_ff   <= onchip_priority_out_o;
			act_prev_ff   <= onchip_activity_out_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_mac_ff <= RCS_CHO_NONE;
		end else if (new_mac) begin
			last_mac_ff <= new_choice;
		end
	end

	// ==========================================================
	// events
	always_comb begin
		ev_set                  = 16'h0000;
		ev_set[RCS_EV_SWITCH]   = new_mac && new_choice != last_mac_ff;
		ev_set[RCS_EV_STARTMID] = (new_choice == RCS_CHO_ONCHIP && onchip_txrx_en_i)
			|| (new_choice == RCS_CHO_EXT && ext_txrx_en_i);
		ev_set[RCS_EV_CLOSEBRK] = enter_closing && owner_txrx;
		ev_set[RCS_EV_BUSY_F]   = busy_prev_ff & ~radio_busy_i;
		ev_set[RCS_EV_BUSY_R]   = ~busy_prev_ff & radio_busy_i;
		ev_set[RCS_EV_ONACT_F]  = onact_prev_ff & ~onchip_active;
		ev_set[RCS_EV_ONACT_R]  = ~onact_prev_ff & onchip_active;
		ev_set[RCS_EV_EXT_F]    = ext_prev_ff & ~ext_active;
		ev_set[RCS_EV_EXT_R]    = ~ext_prev_ff & ext_active;
		ev_set[RCS_EV_PRI_F]    = pri_prev_ff & ~onchip_priority_out_o;
		ev_set[RCS_EV_PRI_R]    = ~pri_prev_ff & onchip_priority_out_o;
		ev_set[RCS_EV_ACT_F]    = act_prev_ff & ~onchip_activity_out_o;
		ev_set[RCS_EV_ACT_R]    = ~act_prev_ff & onchip_activity_out_o;
	end

	always_comb begin
		ev_clr = 16'h0000;
		if (rd && wb_adr_i == A_EVT) begin
			ev_clr = RCS_EV_USED;
		end else if (wr && wb_adr_i == A_CLR) begin
			ev_clr = wb_dat_i[15:0] & wmask & RCS_EV_USED;
		end
	end

	// set wins over a clear in the same cycle
	assign nxt_evt = ((evt_ff & ~ev_clr) | ev_set) & RCS_EV_USED;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_ff <= 16'h0000;
		end else begin
			evt_ff <= nxt_evt;
		end
	end

	// ==========================================================
	// interrupt
	assign agg_flag = |(nxt_evt & mask_ff & RCS_EV_USED);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= agg_flag & mask_ff[RCS_MASK_CPU_BIT];
		end
	end

endmodule : rcs_top

/* tb/rcs_assertions.sv */
// concurrent checks on the ports of the coexistence register bank
`timescale 1ns/1ps
module rcs_checker
	import rcs_pkg::*;
#(
	parameter int CLOSE_CYCLES = RCS_CLOSE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic external_activity_in0_i,
	input wire logic onchip_request_i,
	input wire logic onchip_priority_out_o,
	input wire logic onchip_activity_out_o,
	input wire logic onchip_grant_o,
	input wire logic ext_grant_o,
	input wire logic irq_o
);
	localparam int CLOSE_MAX = CLOSE_CYCLES + 8;
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ==========================================================
	// bus handshake
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	// ==========================================================
	// arbitration outputs
	a_grant_single: assert property (!(onchip_grant_o && ext_grant_o))
		else $error("both grants high");
	a_prio_ext: assert property (ext_grant_o |-> !onchip_priority_out_o)
		else $error("priority high while external owns radio");
	a_prio_act: assert property (onchip_priority_out_o |-> onchip_activity_out_o)
		else $error("priority high without activity");
	a_idle_none: assert property ((!onchip_request_i && !external_activity_in0_i) ##1
		(!onchip_grant_o && !ext_grant_o) |=> (!onchip_grant_o && !ext_grant_o))
		else $error("owner chosen with nobody active");
	a_onchip_cause: assert property ($rose(onchip_grant_o) |-> $past(onchip_request_i, 2))
		else $error("onchip grant without request");
	a_onchip_close: assert property ($fell(onchip_request_i) && onchip_grant_o |-> ##[1:CLOSE_MAX] !onchip_grant_o)
		else $error("onchip grant not released after closing");
	a_ext_close: assert property ($fell(external_activity_in0_i) && ext_grant_o |-> ##[1:CLOSE_MAX] !ext_grant_o)
		else $error("external grant not released after closing");
	c_onchip: cover property ($rose(onchip_grant_o));
	c_ext: cover property ($rose(ext_grant_o));
	c_irq: cover property ($rose(irq_o));
endmodule : rcs_checker

bind rcs_top rcs_checker #(.CLOSE_CYCLES(CLOSE_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .external_activity_in0_i(external_activity_in0_i),
	.onchip_request_i(onchip_request_i), .onchip_priority_out_o(onchip_priority_out_o),
	.onchip_activity_out_o(onchip_activity_out_o), .onchip_grant_o(onchip_grant_o), .ext_grant_o(ext_grant_o),
	.irq_o(irq_o));

/* tb/rcs_ext_mac.sv */
// behavioural external mac on the coexistence pins
`timescale 1ns/1ps
module rcs_ext_mac (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic       early_i,
	input  wire logic       brk_i,
	input  wire logic [7:0] len_i,
	output logic            act_o,
	output logic            txrx_o
);
	// ==========================================================
	// one transfer per go pulse, brk keeps tx/rx past activity
	initial begin
		act_o = 1'h0;
		txrx_o = 1'h0;
	end
	always @(posedge clk_i) begin
		if (go_i) begin
			act_o <= 1'h1;
			txrx_o <= early_i;
			repeat (3) @(posedge clk_i);
			txrx_o <= 1'h1;
			repeat (len_i) @(posedge clk_i);
			act_o <= 1'h0;
			txrx_o <= brk_i;
			repeat (2) @(posedge clk_i);
			txrx_o <= 1'h0;
		end
	end
endmodule : rcs_ext_mac

/* tb/tb.sv */
// self-checking bench of the coexistence register bank
`timescale 1ns/1ps
module tb;
	import rcs_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, onreq, busy, go, early, brk, ext_act, ext_txrx;
	logic        wb_ack_o, pri_o, act_o, ong_o, exg_o, irq_o;
	logic [7:0]  adr, len;
	logic [31:0] wdat, q, wb_dat_o;
	int          mismatches, n_compared;

	rcs_top #(.CLOSE_CYCLES(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.external_activity_in0_i(ext_act), .onchip_request_i(onreq), .onchip_txrx_en_i(1'h0),
		.ext_txrx_en_i(ext_txrx), .radio_busy_i(busy), .onchip_priority_out_o(pri_o),
		.onchip_activity_out_o(act_o), .onchip_grant_o(ong_o), .ext_grant_o(exg_o), .irq_o(irq_o));
	rcs_ext_mac mac (.clk_i(clk_i), .go_i(go), .early_i(early), .brk_i(brk), .len_i(len), .act_o(ext_act),
		.txrx_o(ext_txrx));

	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end
	// ==========================================================
	// shared tasks
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 20);
		q = wb_dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (wb_ack_o !== 1'h1) begin
			mismatches++;
			$display("MISMATCH bus ack expected 1 seen 0");
			give_verdict();
		end
	endtask : bus
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(nm, e, q & m);
	endtask : rdchk
	// ==========================================================
	// scenarios
	task automatic t_reset();
		rdchk("mask", 8'h10, 32'hffffffff, 32'h0);
		rdchk("status", 8'h08, 32'hffffffff, 32'h0);
		rdchk("events", 8'h18, 32'hffffffff, 32'h0);
		rdchk("unmapped", 8'h28, 32'hffffffff, 32'h0);
	endtask : t_reset
	task automatic t_onchip();
		onreq <= 1'h1;
		repeat (4) @(posedge clk_i);
		rdchk("onchip status", 8'h08, 32'hffff, 32'h0321);
		onreq <= 1'h0;
		rdchk("closing", 8'h08, 32'h80, 32'h80);
		repeat (8) @(posedge clk_i);
		rdchk("idle status", 8'h08, 32'h07e0, 32'h0);
		chk("idle pins", 32'h0, {30'h0, pri_o, act_o});
		rdchk("onchip events", 8'h18, 32'hffff, 32'h861e);
		rdchk("events cleared", 8'h18, 32'hffff, 32'h0);
	endtask : t_onchip
	task automatic t_ext(input logic e, input logic b, input logic [7:0] l, input logic [31:0] ev);
		int n;
		n = 0;
		go <= 1'h1;
		early <= e;
		brk <= b;
		len <= l;
		@(posedge clk_i);
		go <= 1'h0;
		repeat (2) @(posedge clk_i);
		rdchk("ext status", 8'h08, 32'hffff, 32'h0462);
		chk("ext grant", 32'h1, {31'h0, exg_o});
		while (ext_act === 1'h1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		if (ext_act !== 1'h0) begin
			mismatches++;
			$display("MISMATCH ext activity expected 0 seen 1");
			give_verdict();
		end
		repeat (10) @(posedge clk_i);
		rdchk("ext events", 8'h18, 32'hffff, ev);
	endtask : t_ext
	task automatic t_irq();
		bus(1'h1, 8'h10, 32'hffff);
		rdchk("mask rw", 8'h10, 32'hffffffff, 32'hfe7f);
		bus(1'h1, 8'h10, 32'h0800);
		busy <= 1'h1;
		repeat (3) @(posedge clk_i);
		chk("irq gated", 32'h0, {31'h0, irq_o});
		bus(1'h1, 8'h10, 32'h0801);
		repeat (2) @(posedge clk_i);
		chk("irq on", 32'h1, {31'h0, irq_o});
		bus(1'h1, 8'h20, 32'h0800);
		busy <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk("irq unmasked event", 32'h0, {31'h0, irq_o});
		rdchk("busy events", 8'h18, 32'hffff, 32'h1000);
	endtask : t_irq
	task automatic t_prog();
		bus(1'h1, 8'h00, 32'h1);
		onreq <= 1'h1;
		repeat (6) @(posedge clk_i);
		chk("prog grant", 32'h0, {31'h0, ong_o});
		rdchk("prog status", 8'h08, 32'h07ff, 32'h0100);
		bus(1'h1, 8'h00, 32'h0);
		repeat (4) @(posedge clk_i);
		chk("grant after prog", 32'h1, {31'h0, ong_o});
		bus(1'h1, 8'h00, 32'h1);
		onreq <= 1'h0;
		repeat (10) @(posedge clk_i);
		rdchk("prog done", 8'h08, 32'h0060, 32'h0);
	endtask : t_prog
	task automatic t_tie();
		int n;
		n = 0;
		bus(1'h1, 8'h00, 32'h2);
		go <= 1'h1;
		len <= 8'h06;
		@(posedge clk_i);
		go <= 1'h0;
		onreq <= 1'h1;
		repeat (2) @(posedge clk_i);
		rdchk("tie status", 8'h08, 32'hffff, 32'h0562);
		while (ext_act === 1'h1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		repeat (8) @(posedge clk_i);
		chk("onchip after ext", 32'h1, {31'h0, ong_o});
		onreq <= 1'h0;
		repeat (10) @(posedge clk_i);
		chk("grants released", 32'h0, {30'h0, ong_o, exg_o});
	endtask : t_tie
	// ==========================================================
	// main sequence
	initial begin
		{rst_i, cyc, stb, we, onreq, busy, go, early, brk} = 9'h100;
		adr = 8'h0;
		len = 8'h6;
		wdat = 32'h0;
		mismatches = 0;
		n_compared = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		t_reset();
		t_onchip();
		t_ext(1'h0, 1'h1, 8'h06, 32'ha060);
		t_ext(1'h1, 1'h0, 8'h14, 32'h4060);
		t_irq();
		t_prog();
		t_tie();
		give_verdict();
	end
endmodule : tb
